// file: core/dbsp_mem_ctrl.sv
// Purpose: controller end; makes the link clocks and runs bursts
// Assumes: one read and one write in flight at most
// Notes:   pins change mid phase so the far end samples stable data
`default_nettype none

module dbsp_mem_ctrl
    import dbsp_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                srst,
    // Mode
    input  wire logic                dll_off,
    // Write requests
    input  wire logic                wr_req,
    output logic                     wr_ready,
    input  wire logic [HOST_AW-1:0]  wr_addr,
    input  wire logic [LINE_W-1:0]   wr_data,
    input  wire logic [MASK_W-1:0]   wr_mask_n,
    // Read requests and answers
    input  wire logic                rd_req,
    output logic                     rd_ready,
    input  wire logic [HOST_AW-1:0]  rd_addr,
    output logic                     rd_valid,
    output logic [LINE_W-1:0]        rd_data,
    // Link
    dbsp_link_if.ctrl                link
);
    // Bank this controller's device answers to
    localparam logic BANK_SEL = 1'b0;

    typedef enum logic [1:0] {
        DBSP_IDLE = 2'b00,
        DBSP_PEND = 2'b01,
        DBSP_BUSY = 2'b10
    } dbsp_st_e;

    dbsp_st_e              rd_st_reg, rd_st_next, wr_st_reg, wr_st_next;
    logic [2:0]            div_reg, div_next;
    logic                  k_reg, k_next, oc_reg, oc_next;
    logic                  slot_reg, slot_next;
    logic [3:0]            g_reg, g_next, e_reg, e_next;
    logic [3:0]            tgt_reg, tgt_next;
    logic [1:0]            ridx_reg, ridx_next, widx_reg, widx_next;
    logic [HOST_AW-1:0]    raddr_reg, raddr_next, waddr_reg, waddr_next;
    logic [LINE_W-1:0]     wbuf_reg, wbuf_next, rbuf_reg, rbuf_next;
    logic [MASK_W-1:0]     wmsk_reg, wmsk_next;
    logic [ADDR_W-1:0]     addr_reg, addr_next;
    logic                  rps_reg, rps_next, wps_reg, wps_next;
    logic                  byp_reg, byp_next;
    logic [WORD_W-1:0]     d_reg, d_next, rds1_reg, rds2_reg;
    logic [LANES-1:0]      m_reg, m_next;
    logic                  es1_reg, es2_reg, es3_reg;
    logic                  wrdy_reg, wrdy_next, rrdy_reg, rrdy_next;
    logic                  rval_reg, rval_next;

    assign link.in_clk                 = k_reg;
    assign link.out_clk                = oc_reg;
    assign link.addr                   = addr_reg;
    assign link.read_port_select_n     = rps_reg;
    assign link.write_port_select_n    = wps_reg;
    assign link.dll_bypass_pin         = byp_reg;
    assign link.wr_data                = d_reg;
    assign link.byte_lane_write_mask_n = m_reg;
    assign wr_ready = wrdy_reg;
    assign rd_ready = rrdy_reg;
    assign rd_valid = rval_reg;
    assign rd_data  = rbuf_reg;

    // Clock divider, pin scheduling and read capture
    always_comb begin
        div_next   = (div_reg == K_LAST_CYC) ? 3'h0 : 3'(div_reg + 3'h1);
        k_next     = k_reg;
        oc_next    = oc_reg;
        slot_next  = slot_reg;
        g_next     = g_reg;
        e_next     = e_reg;
        tgt_next   = tgt_reg;
        ridx_next  = ridx_reg;
        widx_next  = widx_reg;
        raddr_next = raddr_reg;
        waddr_next = waddr_reg;
        wbuf_next  = wbuf_reg;
        wmsk_next  = wmsk_reg;
        rbuf_next  = rbuf_reg;
        addr_next  = addr_reg;
        rps_next   = rps_reg;
        wps_next   = wps_reg;
        d_next     = d_reg;
        m_next     = m_reg;
        rd_st_next = rd_st_reg;
        wr_st_next = wr_st_reg;
        rval_next  = 1'b0;
        byp_next   = dll_off;
        // Both clocks toggle together; out_clk mirrors in_clk
        if (div_reg == K_LAST_CYC) begin
            k_next  = ~k_reg; // [R13]
            oc_next = ~k_reg;
            g_next  = 4'(g_reg + 4'h1);
            if (!k_reg) begin
                slot_next = ~slot_reg; // [R2]
            end
        end
        if (rd_st_reg == DBSP_IDLE && rd_req) begin
            raddr_next = rd_addr;
            rd_st_next = DBSP_PEND;
        end
        if (wr_st_reg == DBSP_IDLE && wr_req) begin
            waddr_next = wr_addr;
            wbuf_next  = wr_data;
            wmsk_next  = wr_mask_n;
            wr_st_next = DBSP_PEND;
        end
        // Mid phase: set up pins for the coming edge
        if (div_reg == K_MID_CYC) begin
            rps_next = 1'b1;
            wps_next = 1'b1;
            if (!k_reg && !slot_reg && rd_st_reg == DBSP_PEND) begin
                if (raddr_reg[HOST_AW-1] == BANK_SEL) begin // [R10]
                    rps_next   = 1'b0; // [R18]
                    addr_next  = raddr_reg[ADDR_W-1:0]; // [R2]
                    tgt_next   = 4'(g_reg + (dll_off ? RD_LAT_BYP_HALF
                                                     : RD_LAT_DLL_HALF));
                    ridx_next  = 2'h0;
                    rd_st_next = DBSP_BUSY;
                end else begin
                    // Other bank: no device answers, return zeros
                    rbuf_next  = '0;
                    rval_next  = 1'b1;
                    rd_st_next = DBSP_IDLE;
                end
            end
            if (!k_reg && slot_reg && wr_st_reg == DBSP_PEND) begin
                if (waddr_reg[HOST_AW-1] == BANK_SEL) begin // [R10]
                    wps_next   = 1'b0; // [R15]
                    addr_next  = waddr_reg[ADDR_W-1:0]; // [R2]
                    d_next     = wbuf_reg[WORD_W-1:0];
                    m_next     = wmsk_reg[LANES-1:0]; // [R17]
                    widx_next  = 2'h1;
                    wr_st_next = DBSP_BUSY;
                end else begin
                    wr_st_next = DBSP_IDLE;
                end
            end else if (wr_st_reg == DBSP_BUSY) begin
                // One word per phase, both edges carry data
                d_next    = wbuf_reg[widx_reg*WORD_W +: WORD_W]; // [R4]
                m_next    = wmsk_reg[widx_reg*LANES +: LANES]; // [R17]
                widx_next = 2'(widx_reg + 2'h1);
                if (widx_reg == 2'h3) begin
                    wr_st_next = DBSP_IDLE;
                end
            end
        end
        // Echo edges are numbered like the clock edges we made
        if (es2_reg != es3_reg) begin
            e_next = 4'(e_reg + 4'h1);
            if (rd_st_reg == DBSP_BUSY &&
                e_reg == 4'(tgt_reg + {2'h0, ridx_reg})) begin // [R11]
                rbuf_next[ridx_reg*WORD_W +: WORD_W] = rds2_reg;
                ridx_next = 2'(ridx_reg + 2'h1);
                if (ridx_reg == 2'h3) begin
                    rval_next  = 1'b1;
                    rd_st_next = DBSP_IDLE;
                end
            end
        end
        rrdy_next = (rd_st_next == DBSP_IDLE);
        wrdy_next = (wr_st_next == DBSP_IDLE);
    end

    // State registers; echo and read data pass two flip-flops
    always_ff @(posedge core_clk) begin
        es1_reg  <= link.echo_strobe_out;
        es2_reg  <= es1_reg;
        rds1_reg <= link.rd_data;
        rds2_reg <= rds1_reg;
        if (srst) begin
            rd_st_reg <= DBSP_IDLE;
            wr_st_reg <= DBSP_IDLE;
            div_reg   <= 3'h0;
            k_reg     <= 1'b0;
            oc_reg    <= 1'b0;
            slot_reg  <= 1'b0;
            g_reg     <= 4'h0;
            e_reg     <= 4'h0;
            tgt_reg   <= 4'h0;
            ridx_reg  <= 2'h0;
            widx_reg  <= 2'h0;
            raddr_reg <= '0;
            waddr_reg <= '0;
            wbuf_reg  <= '0;
            wmsk_reg  <= '1;
            rbuf_reg  <= '0;
            addr_reg  <= '0;
            rps_reg   <= 1'b1;
            wps_reg   <= 1'b1;
            byp_reg   <= 1'b0;
            d_reg     <= '0;
            m_reg     <= '1;
            es3_reg   <= 1'b0;
            wrdy_reg  <= 1'b0;
            rrdy_reg  <= 1'b0;
            rval_reg  <= 1'b0;
        end else begin
            rd_st_reg <= rd_st_next;
            wr_st_reg <= wr_st_next;
            div_reg   <= div_next;
            k_reg     <= k_next;
            oc_reg    <= oc_next;
            slot_reg  <= slot_next;
            g_reg     <= g_next;
            e_reg     <= e_next;
            tgt_reg   <= tgt_next;
            ridx_reg  <= ridx_next;
            widx_reg  <= widx_next;
            raddr_reg <= raddr_next;
            waddr_reg <= waddr_next;
            wbuf_reg  <= wbuf_next;
            wmsk_reg  <= wmsk_next;
            rbuf_reg  <= rbuf_next;
            addr_reg  <= addr_next;
            rps_reg   <= rps_next;
            wps_reg   <= wps_next;
            byp_reg   <= byp_next;
            d_reg     <= d_next;
            m_reg     <= m_next;
            es3_reg   <= es2_reg;
            wrdy_reg  <= wrdy_next;
            rrdy_reg  <= rrdy_next;
            rval_reg  <= rval_next;
        end
    end
endmodule

`default_nettype wire

// file: core/dbsp_mem_dev.sv
// Purpose: memory end of the burst-of-four DDR static memory link
// Assumes: core_clk is much faster than the link clocks; every link
//          input is asynchronous and passes two flip-flops first
// Notes:   wide configuration only; srst stands in for power-up state
`default_nettype none

// How it works
// [R1] Separate read and write data ports, concurrent
// [R2] Read, write addresses on alternate rising edges
// [R3] Each address selects four sequential words
// [R4] One word per edge of each clock
// [R5] All inputs captured on input clock edges
// [R6] Reads launched on output clock, else input
// [R7] DLL on: data after 1.5 cycles
// [R8] DLL bypassed: data after one cycle
// [R9] Writes self-timed, no extra strobes needed
// [R10] Independent port selects for depth stacking
// [R11] Complementary echo strobes aligned with data
// [R12] Reads return newest data, even in-flight
// [R13] Controller keeps input clock at most 300 MHz
// [R14] Wide array: 1M words of 36 bits
// [R15] Write select low starts write, else ignored
// [R16] Low mask bit writes its 9-bit lane
// [R17] Masks sampled with their own data word
// [R18] Read select low starts four-word read
// [R19] Burst words in fixed ascending order
module dbsp_mem_dev
    import dbsp_pkg::*;
(
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   srst,
    // Board strap: launch reads from the input clock pair
    input  wire logic   single_clk_mode,
    // Link to the controller
    dbsp_link_if.dev    link,
    // Status
    output logic        rd_burst_busy,
    output logic        wr_burst_busy
);
    // Input synchronisers and edge history
    logic [PIN_W-1:0]   sync1_reg, sync2_reg;
    logic               kprev_reg, kprev_next;
    logic               oprev_reg, oprev_next;
    // Decoded synchronised pins
    logic               k_s, oc_s, rps_n_s, wps_n_s, byp_s;
    logic [ADDR_W-1:0]  addr_s;
    logic [LANES-1:0]   mask_s;
    logic [WORD_W-1:0]  d_s;
    // Edge events
    logic               k_rise, k_edge, o_sel, o_edge;
    // Slot parity: even rising edges carry reads
    logic               slot_reg, slot_next;
    // Pending read waiting out its latency
    logic               pend_reg, pend_next;
    logic [3:0]         pcnt_reg, pcnt_next;
    logic [ADDR_W-1:0]  paddr_reg, paddr_next;
    // Read burst in progress
    logic               rb_reg, rb_next;
    logic [1:0]         ridx_reg, ridx_next;
    logic [ADDR_W-1:0]  raddr_reg, raddr_next;
    logic [WORD_W-1:0]  q_reg, q_next;
    // Write burst in progress
    logic               wb_reg, wb_next;
    logic [1:0]         widx_reg, widx_next;
    logic [ADDR_W-1:0]  waddr_reg, waddr_next;
    // Echo strobes
    logic               echo_reg, echo_n_reg;
    // Array port for this cycle
    logic               we_c;
    logic [MEM_AW-1:0]  wa_c, ra_c;
    logic [WORD_W-1:0]  wnew_c, rword_c;
    logic               launch_c;

    // Storage: one aligned group of four words per address
    logic [WORD_W-1:0]  mem_arr [0:MEM_WORDS-1]; // [R14]

    // Replace only the lanes whose mask is low
    function automatic logic [WORD_W-1:0] lane_merge(
        input logic [WORD_W-1:0] old_w,
        input logic [WORD_W-1:0] new_w,
        input logic [LANES-1:0]  msk_n
    );
        logic [WORD_W-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!msk_n[i]) begin
                res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction

    assign {k_s, oc_s, rps_n_s, wps_n_s, byp_s, addr_s, mask_s, d_s} =
        sync2_reg;

    // Only the second flop of each synchroniser feeds logic
    assign k_rise = k_s & ~kprev_reg;
    assign k_edge = k_s ^ kprev_reg; // [R5]
    assign o_sel  = single_clk_mode ? k_s : oc_s; // [R6]
    assign o_edge = o_sel ^ oprev_reg;

    // Read and write ports are separate pins, no turnaround
    assign link.rd_data           = q_reg; // [R1]
    assign link.echo_strobe_out   = echo_reg;
    assign link.echo_strobe_out_n = echo_n_reg;
    assign rd_burst_busy          = rb_reg;
    assign wr_burst_busy          = wb_reg;

    // Write side: capture one word per input edge
    always_comb begin
        slot_next  = slot_reg;
        wb_next    = wb_reg;
        widx_next  = widx_reg;
        waddr_next = waddr_reg;
        we_c       = 1'b0;
        wa_c       = {waddr_reg, widx_reg};
        if (k_rise) begin
            slot_next = ~slot_reg; // [R2]
        end
        if (k_rise && slot_reg && !wps_n_s) begin // [R15]
            // Word 0 rides on the same edge as the address
            we_c       = 1'b1; // [R9]
            wa_c       = {addr_s, 2'h0}; // [R3]
            waddr_next = addr_s;
            wb_next    = 1'b1;
            widx_next  = 2'h1;
        end else if (k_edge && wb_reg) begin
            we_c      = 1'b1; // [R4]
            widx_next = 2'(widx_reg + 2'h1); // [R19]
            if (widx_reg == 2'h3) begin
                wb_next = 1'b0;
            end
        end
        // Mask travels with its own word on either edge
        wnew_c = lane_merge(mem_arr[wa_c], d_s, mask_s); // [R16] [R17]
    end

    // Read side: latency countdown, then one word per output edge
    always_comb begin
        pend_next  = pend_reg;
        pcnt_next  = pcnt_reg;
        paddr_next = paddr_reg;
        rb_next    = rb_reg;
        ridx_next  = ridx_reg;
        raddr_next = raddr_reg;
        q_next     = q_reg;
        launch_c   = 1'b0;
        ra_c       = {raddr_reg, ridx_reg};
        // Reads are four edges apart and latency is under four, so
        // a single pending slot is enough
        if (k_rise && !slot_reg && !rps_n_s) begin // [R18]
            pend_next  = 1'b1;
            paddr_next = addr_s; // [R3]
            pcnt_next  = byp_s ? RD_LAT_BYP_HALF // [R8]
                               : RD_LAT_DLL_HALF; // [R7]
        end else if (o_edge && pend_reg) begin
            if (pcnt_reg == 4'h1) begin
                pend_next  = 1'b0;
                launch_c   = 1'b1;
                rb_next    = 1'b1;
                raddr_next = paddr_reg;
                ridx_next  = 2'h1;
                ra_c       = {paddr_reg, 2'h0};
            end else begin
                pcnt_next = 4'(pcnt_reg - 4'h1);
            end
        end
        if (o_edge && !launch_c && rb_reg) begin
            launch_c  = 1'b1; // [R4]
            ridx_next = 2'(ridx_reg + 2'h1); // [R19]
            if (ridx_reg == 2'h3) begin
                rb_next = 1'b0;
            end
        end
        // A word being written this cycle is forwarded to the read
        rword_c = (we_c && wa_c == ra_c) ? wnew_c : mem_arr[ra_c]; // [R12]
        if (launch_c) begin
            q_next = rword_c; // [R6]
        end
        kprev_next = k_s;
        oprev_next = o_sel;
    end

    // Array write; no reset, contents are undefined at power-up
    always_ff @(posedge core_clk) begin
        if (we_c) begin
            mem_arr[wa_c] <= wnew_c; // [R9]
        end
    end

    // Control and output registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            kprev_reg  <= 1'b0;
            oprev_reg  <= 1'b0;
            slot_reg   <= 1'b0;
            pend_reg   <= 1'b0;
            pcnt_reg   <= 4'h0;
            paddr_reg  <= '0;
            rb_reg     <= 1'b0;
            ridx_reg   <= 2'h0;
            raddr_reg  <= '0;
            q_reg      <= '0;
            wb_reg     <= 1'b0;
            widx_reg   <= 2'h0;
            waddr_reg  <= '0;
            echo_reg   <= 1'b0;
            echo_n_reg <= 1'b1;
        end else begin
            sync1_reg  <= {link.in_clk, link.out_clk,
                           link.read_port_select_n,
                           link.write_port_select_n, link.dll_bypass_pin,
                           link.addr, link.byte_lane_write_mask_n,
                           link.wr_data};
            sync2_reg  <= sync1_reg;
            kprev_reg  <= kprev_next;
            oprev_reg  <= oprev_next;
            slot_reg   <= slot_next;
            pend_reg   <= pend_next;
            pcnt_reg   <= pcnt_next;
            paddr_reg  <= paddr_next;
            rb_reg     <= rb_next;
            ridx_reg   <= ridx_next;
            raddr_reg  <= raddr_next;
            q_reg      <= q_next;
            wb_reg     <= wb_next;
            widx_reg   <= widx_next;
            waddr_reg  <= waddr_next;
            // Echo follows the launch clock, so it toggles with data
            echo_reg   <= o_sel; // [R11]
            echo_n_reg <= ~o_sel;
        end
    end
endmodule

`default_nettype wire

// file: include/dbsp_link_if.sv
// Purpose: pins between the memory controller and the memory end
// Assumes: both ends run on their own core_clk and sample these pins
// Notes:   no tristate pins; read and write data travel apart
`default_nettype none

interface dbsp_link_if;
    import dbsp_pkg::*;
    // Clocks made by the controller
    logic                  in_clk;
    logic                  out_clk;
    // Address and selects
    logic [ADDR_W-1:0]     addr;
    logic                  read_port_select_n;
    logic                  write_port_select_n;
    logic                  dll_bypass_pin;
    // Write data and lane masks
    logic [WORD_W-1:0]     wr_data;
    logic [LANES-1:0]      byte_lane_write_mask_n;
    // Read data and echo strobes
    logic [WORD_W-1:0]     rd_data;
    logic                  echo_strobe_out;
    logic                  echo_strobe_out_n;

    modport dev (
        input  in_clk, out_clk, addr, read_port_select_n,
        input  write_port_select_n, dll_bypass_pin, wr_data,
        input  byte_lane_write_mask_n,
        output rd_data, echo_strobe_out, echo_strobe_out_n
    );
    modport ctrl (
        output in_clk, out_clk, addr, read_port_select_n,
        output write_port_select_n, dll_bypass_pin, wr_data,
        output byte_lane_write_mask_n,
        input  rd_data, echo_strobe_out, echo_strobe_out_n
    );
endinterface

`default_nettype wire

// file: include/dbsp_pkg.sv
// Purpose: shared constants for the burst-of-four DDR static memory link
// Assumes: wide configuration only, 1M locations of 36 bits
// Notes:   link clock is made by the controller from core_clk
`default_nettype none

package dbsp_pkg;
    // Data path shape
    localparam int WORD_W    = 36;
    localparam int LANE_W    = 9;
    localparam int LANES     = 4;
    localparam int BURST_LEN = 4;
    localparam int LINE_W    = WORD_W * BURST_LEN;
    localparam int MASK_W    = LANES * BURST_LEN;
    // Depth: one address picks a group of four words
    localparam int MEM_WORDS = 1048576;
    localparam int MEM_AW    = 20;
    localparam int ADDR_W    = MEM_AW - 2;
    // Controller side address carries one bank bit above the device
    localparam int HOST_AW   = ADDR_W + 1;
    // Input pin vector seen by the memory end
    localparam int PIN_W     = 5 + ADDR_W + LANES + WORD_W;
    // Read latency counted in half link cycles
    localparam logic [3:0] RD_LAT_DLL_HALF = 4'h3;
    localparam logic [3:0] RD_LAT_BYP_HALF = 4'h2;
    // Link clock timing; far below the 300 MHz ceiling of the part
    localparam int CORE_PERIOD_NS = 10;
    localparam int LINK_PERIOD_NS = 80;
    localparam int MAX_LINK_MHZ   = 300;
    localparam int K_HALF_INT = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam logic [2:0] K_LAST_CYC = 3'(K_HALF_INT - 1);
    localparam logic [2:0] K_MID_CYC  = 3'(K_HALF_INT / 2 - 1);
endpackage

`default_nettype wire

// file: verif/dbsp_link_monitor.sv
// Purpose: pin level checks on the link between the two ends
// Assumes: both ends run on core_clk and leave reset together
// Notes:   edge counts are kept in small helper registers
`default_nettype none

module dbsp_link_monitor
    import dbsp_pkg::*;
(
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              srst,
    // Link pins
    input wire logic              in_clk,
    input wire logic              out_clk,
    input wire logic              read_port_select_n,
    input wire logic              write_port_select_n,
    input wire logic [WORD_W-1:0] rd_data,
    input wire logic              echo_strobe_out,
    input wire logic              echo_strobe_out_n
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_d_reg, clk_d_next;
    logic [2:0] wr_edg_reg, wr_edg_next;
    logic [2:0] rd_ris_reg, rd_ris_next;

    // Input clock edges seen while write select is low, rises while read select is low
    always_comb begin
        clk_d_next  = in_clk;
        wr_edg_next = write_port_select_n ? 3'h0
                    : wr_edg_reg + 3'(in_clk != clk_d_reg);
        rd_ris_next = read_port_select_n ? 3'h0
                    : rd_ris_reg + 3'(in_clk && !clk_d_reg);
    end

    // Cleared in reset so a burst cut short does not leak into the next
    always_ff @(posedge core_clk) begin
        clk_d_reg  <= srst ? 1'b0 : clk_d_next;
        wr_edg_reg <= srst ? 3'h0 : wr_edg_next;
        rd_ris_reg <= srst ? 3'h0 : rd_ris_next;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    // Select goes low at mid phase, ahead of the rise that takes it
    sequence wr_start; $fell(write_port_select_n); endsequence
    sequence slot_rise; ##[1:3] $rose(in_clk); endsequence

    AST_ECHO_PAIR: assert property (
        echo_strobe_out != echo_strobe_out_n)
        else $error("echo strobes not complementary");
    AST_CLKS_TOGETHER: assert property (
        in_clk == out_clk)
        else $error("input and output clocks apart");
    AST_HALF_PERIOD: assert property (
        $rose(in_clk) |-> in_clk[*4] ##1 !in_clk)
        else $error("link clock half period wrong");
    AST_WR_SEL_MID: assert property (
        wr_start |-> slot_rise)
        else $error("write select not ahead of a rise");
    // Select is a one-slot pulse; the burst words follow on their own
    AST_WR_ONE_SLOT: assert property (
        $rose(write_port_select_n) |-> wr_edg_reg == 3'h1)
        else $error("write select spans wrong edges");
    AST_RD_ONE_SLOT: assert property (
        $rose(read_port_select_n) |-> rd_ris_reg == 3'h1)
        else $error("read select spans wrong rises");
    AST_DATA_ECHO: assert property (
        $changed(rd_data) |-> $changed(echo_strobe_out))
        else $error("read word moved without echo");
    AST_ECHO_FOLLOW: assert property (
        $changed(out_clk) |-> ##[2:4] $changed(echo_strobe_out))
        else $error("echo does not follow output clock");
endmodule

`default_nettype wire

// file: verif/tb_ddr_burst4_sram_port.sv
// Purpose: drives both ends through their user sides
// Assumes: controller makes the link clocks from core_clk
// Notes:   latency is compared between modes, not as an absolute
`default_nettype none

module tb_ddr_burst4_sram_port
    import dbsp_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk, srst, dll_off, single_clk_mode;
    logic wr_req, wr_ready, rd_req, rd_ready, rd_valid, arm = 1'b0;
    logic [HOST_AW-1:0] wr_addr, rd_addr;
    logic [LINE_W-1:0]  wr_data, rd_data;
    logic [MASK_W-1:0]  wr_mask_n;
    int                 miscompares, compares, lat_on, cyc = 0, lat = 0;

    localparam logic [HOST_AW-1:0] A0 = 19'h0_0005;
    localparam logic [HOST_AW-1:0] A1 = 19'h3_FFFF;
    localparam logic [HOST_AW-1:0] BANK = 19'h4_0000;
    localparam logic [LINE_W-1:0] D1 = {36'h4_4444_4444, 36'h3_3333_3333,
                                        36'h2_2222_2222, 36'h1_1111_1111};
    localparam logic [LINE_W-1:0] D2 = D1 ^ {4{36'hF_0F0F_0F0F}};

    dbsp_link_if dbsp_link_if_i ();
    dbsp_mem_ctrl dbsp_mem_ctrl_i (.core_clk, .srst, .dll_off, .wr_req,
        .wr_ready, .wr_addr, .wr_data, .wr_mask_n, .rd_req, .rd_ready,
        .rd_addr, .rd_valid, .rd_data, .link(dbsp_link_if_i));
    dbsp_mem_dev dbsp_mem_dev_i (.core_clk, .srst, .single_clk_mode,
        .link(dbsp_link_if_i), .rd_burst_busy(), .wr_burst_busy());
    dbsp_link_monitor dbsp_link_monitor_i (.core_clk, .srst,
        .in_clk(dbsp_link_if_i.in_clk), .out_clk(dbsp_link_if_i.out_clk),
        .read_port_select_n(dbsp_link_if_i.read_port_select_n),
        .write_port_select_n(dbsp_link_if_i.write_port_select_n),
        .rd_data(dbsp_link_if_i.rd_data),
        .echo_strobe_out(dbsp_link_if_i.echo_strobe_out),
        .echo_strobe_out_n(dbsp_link_if_i.echo_strobe_out_n));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [LINE_W-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    // Lane i of word k kept where mask bit 4k+i is high
    function automatic logic [LINE_W-1:0] merge(
        input logic [LINE_W-1:0] o, n, input logic [MASK_W-1:0] m);
        for (int i = 0; i < LINE_W; i++) begin
            merge[i] = m[(i / WORD_W) * LANES + (i % WORD_W) / LANE_W]
                     ? o[i] : n[i];
        end
    endfunction

    task automatic wr(input logic [HOST_AW-1:0] a,
        input logic [LINE_W-1:0] d, input logic [MASK_W-1:0] m);
        @(posedge core_clk);
        while (wr_ready !== 1'b1) @(posedge core_clk);
        wr_req <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        wr_mask_n <= m;
        @(posedge core_clk);
        wr_req <= 1'b0;
        @(posedge core_clk);
        while (wr_ready !== 1'b1) @(posedge core_clk);
    endtask

    task automatic rd(input logic [HOST_AW-1:0] a, input logic [LINE_W-1:0] e);
        @(posedge core_clk);
        while (rd_ready !== 1'b1) @(posedge core_clk);
        rd_req <= 1'b1;
        rd_addr <= a;
        @(posedge core_clk);
        rd_req <= 1'b0;
        while (rd_valid !== 1'b1) @(posedge core_clk);
        cmp(rd_data, e);
    endtask

    // Timeout, and cycles from read select to first returned word
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if ($fell(dbsp_link_if_i.read_port_select_n)) begin
            arm <= 1'b1;
            lat <= 0;
        end else if (arm) begin
            lat <= lat + 1;
            if ($changed(dbsp_link_if_i.rd_data)) arm <= 1'b0;
        end
        if (cyc > 20000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        {srst, dll_off, single_clk_mode, wr_req, rd_req} = 5'h10;
        {wr_addr, rd_addr, wr_data} = '0;
        wr_mask_n = '1;
        {miscompares, compares} = '0;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        wr(A0, D1, 16'h0000);
        rd(A0, D1);
        lat_on = lat;
        wr(A0, ~D1, 16'hA5C3);
        rd(A0, merge(D1, ~D1, 16'hA5C3));
        wr(A0 | BANK, D2, 16'h0000);
        rd(A0 | BANK, '0);
        fork
            wr(A1, D2, 16'h0000);
            rd(A0, merge(D1, ~D1, 16'hA5C3));
        join
        rd(A1, D2);
        dll_off <= 1'b1;
        rd(A1, D2);
        cmp(LINE_W'(lat_on - lat), LINE_W'(K_HALF_INT));
        single_clk_mode <= 1'b1;
        wr(A1, D1, 16'hFFFF);
        rd(A1, D2);
        stop_test();
    end
endmodule

`default_nettype wire
